// ==== core/isp_defs.svh ====
// constants of the serial programming port
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// ==========================================
// timing
`define ISP_CLK_MHZ 250
`define ISP_PAGE_WAIT_US 4500
`define ISP_FUSE_WAIT_US 4500
`define ISP_EE_WAIT_US 9000
`define ISP_ERASE_WAIT_US 9000
`define ISP_PAGE_WAIT_CYC (`ISP_PAGE_WAIT_US * `ISP_CLK_MHZ)
`define ISP_FUSE_WAIT_CYC (`ISP_FUSE_WAIT_US * `ISP_CLK_MHZ)
`define ISP_EE_WAIT_CYC (`ISP_EE_WAIT_US * `ISP_CLK_MHZ)
`define ISP_ERASE_WAIT_CYC (`ISP_ERASE_WAIT_US * `ISP_CLK_MHZ)
`define ISP_CNT_W 22

// ==========================================
// geometry and frame positions
`define ISP_FLASH_WAW 13
`define ISP_PAGE_WAW 6
`define ISP_EE_AW 9
`define ISP_BIT_HDR 5'h17
`define ISP_BIT_LAST 5'h1f
`define ISP_BIT_ECHO 5'h10
`define ISP_BIT_ANS 5'h18

// ==========================================
// opcodes and values
`define ISP_OP_AC 8'hac
`define ISP_OP_EN2 8'h53
`define ISP_OP_ERASE2 8'h80
`define ISP_OP_POLL 8'hf0
`define ISP_OP_LD_LO 8'h40
`define ISP_OP_LD_HI 8'h48
`define ISP_OP_RD_LO 8'h20
`define ISP_OP_RD_HI 8'h28
`define ISP_OP_RD_EE 8'ha0
`define ISP_OP_WR_PAGE 8'h4c
`define ISP_OP_WR_EE 8'hc0
`define ISP_OP_RD_FUSE 8'h50
`define ISP_OP_RD_LOCK 8'h58
`define ISP_OP_RD_SIG 8'h30
`define ISP_OP_RD_CAL 8'h38
`define ISP_SEL_HI 8'h08
`define ISP_WR_LOCK 8'he0
`define ISP_WR_FUSE 8'ha0
`define ISP_WR_FUSE_HI 8'ha8
`define ISP_WR_FUSE_EXT 8'ha4
`define ISP_ERASED 8'hff
`define ISP_FUSE_RST 8'hff
`define ISP_RD_NONE 8'h00

`endif

// ==== core/isp_pkg.sv ====
// types of the serial programming port
package isp_pkg;
   typedef enum logic [2:0] {
      ISP_OP_NONE,
      ISP_OP_PAGE,
      ISP_OP_EE,
      ISP_OP_ERASE,
      ISP_OP_FUSE
   } isp_op_t;

   typedef struct packed {
      logic [7:0] op;
      logic [7:0] hi;
      logic [7:0] lo;
   } isp_hdr_t;

   typedef struct packed {
      isp_hdr_t hdr;
      logic [7:0] data;
   } isp_frame_t;
endpackage

// ==== core/isp_port.sv ====
// serial in-system programming port with its memories
`timescale 1ns/1ps
`include "isp_defs.svh"
module isp_port #(
   parameter int FLASH_WAW = `ISP_FLASH_WAW,
   parameter int PAGE_WAW = `ISP_PAGE_WAW,
   parameter int EE_AW = `ISP_EE_AW,
   parameter int CNT_W = `ISP_CNT_W,
   parameter int PAGE_WAIT_CYC = `ISP_PAGE_WAIT_CYC,
   parameter int FUSE_WAIT_CYC = `ISP_FUSE_WAIT_CYC,
   parameter int EE_WAIT_CYC = `ISP_EE_WAIT_CYC,
   parameter int ERASE_WAIT_CYC = `ISP_ERASE_WAIT_CYC,
   // identity values below are arbitrary
   parameter logic [23:0] SIGNATURE = 24'h5a3c01,
   parameter logic [7:0] CALIBRATION = 8'h80
) (
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   input wire logic PROG_RESETN_I,
   input wire logic SER_CLK_I,
   input wire logic SER_DATA_I,
   output logic SER_DATA_O,
   output logic PROG_MODE_O,
   output logic OPERATION_PENDING_FLAG_O
);
   localparam int FB_W = FLASH_WAW + 1;
   localparam int PB_W = PAGE_WAW + 1;
   localparam int PG_W = FLASH_WAW - PAGE_WAW;
   localparam int FLASH_BYTES = 2 ** FB_W;
   localparam int PAGE_BYTES = 2 ** PB_W;
   localparam int EE_BYTES = 2 ** EE_AW;

   // ==========================================
   // link side, clocked by the serial clock
   // counter is cleared whenever the programmer lets reset go high,
   // which is how a lost frame alignment is recovered
   logic sck_arst_n;
   logic [4:0] bit_cnt_r;
   logic [31:0] shift_in_r;
   logic [7:0] out_sr_r;
   isp_pkg::isp_hdr_t hdr_r;
   isp_pkg::isp_frame_t frame_r;
   logic hdr_tgl_r;
   logic frame_tgl_r;
   logic [7:0] rd_byte_r;

   assign sck_arst_n = RESETN_I & ~PROG_RESETN_I;

   always_ff @(posedge SER_CLK_I or negedge sck_arst_n) begin
      if (!sck_arst_n) begin
         bit_cnt_r <= 5'h00;
         shift_in_r <= 32'h0000_0000;
      end else begin
         shift_in_r <= {shift_in_r[30:0], SER_DATA_I};
         bit_cnt_r <= bit_cnt_r + 5'h01;
      end
   end

   // toggles only reset with the system, so a pin reset never fakes
   // a frame event on the far side
   always_ff @(posedge SER_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         hdr_r <= '0;
         frame_r <= '0;
         hdr_tgl_r <= 1'b0;
         frame_tgl_r <= 1'b0;
      end else if (bit_cnt_r == `ISP_BIT_HDR && !PROG_RESETN_I) begin
         hdr_r <= {shift_in_r[22:0], SER_DATA_I};
         hdr_tgl_r <= ~hdr_tgl_r;
      end else if (bit_cnt_r == `ISP_BIT_LAST && !PROG_RESETN_I) begin
         frame_r <= {shift_in_r[30:0], SER_DATA_I};
         frame_tgl_r <= ~frame_tgl_r;
      end
   end

   // rd_byte_r is quasi-static here: it settles in the system domain
   // well before the high phase of bit 24 ends
   always_ff @(negedge SER_CLK_I or negedge sck_arst_n) begin
      if (!sck_arst_n) begin
         out_sr_r <= 8'h00;
      end else if (bit_cnt_r == `ISP_BIT_ECHO) begin
         out_sr_r <= shift_in_r[7:0];
      end else if (bit_cnt_r == `ISP_BIT_ANS) begin
         out_sr_r <= rd_byte_r;
      end else begin
         out_sr_r <= {out_sr_r[6:0], 1'b0};
      end
   end

   assign SER_DATA_O = out_sr_r[7];

   // ==========================================
   // crossings into the system clock
   logic pin_s1_r;
   logic pin_s2_r;
   logic [2:0] hdr_sync_r;
   logic [2:0] frame_sync_r;
   logic prog_act;
   logic rd_ev;
   logic wr_ev;

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         hdr_sync_r <= 3'h0;
         frame_sync_r <= 3'h0;
      end else begin
         pin_s1_r <= PROG_RESETN_I;
         pin_s2_r <= pin_s1_r;
         hdr_sync_r <= {hdr_sync_r[1:0], hdr_tgl_r};
         frame_sync_r <= {frame_sync_r[1:0], frame_tgl_r};
      end
   end

   assign prog_act = ~pin_s2_r;
   assign rd_ev = hdr_sync_r[2] ^ hdr_sync_r[1];
   assign wr_ev = frame_sync_r[2] ^ frame_sync_r[1];

   // ==========================================
   // instruction decode
   logic enabled_r;
   isp_pkg::isp_op_t op_r;
   logic [CNT_W-1:0] cnt_r;
   logic [PG_W-1:0] page_r;
   logic [EE_AW-1:0] ee_addr_r;
   logic [7:0] ee_data_r;
   logic pend_r;
   logic [7:0] fuse_lo_r;
   logic [7:0] fuse_hi_r;
   logic [7:0] fuse_ext_r;
   logic [7:0] lock_r;
   logic [7:0] flash_mem [FLASH_BYTES];
   logic [7:0] pbuf [PAGE_BYTES];
   logic [7:0] ee_mem [EE_BYTES];

   isp_pkg::isp_op_t kind;
   logic [FLASH_WAW-1:0] wr_word;
   logic [FLASH_WAW-1:0] rd_word;
   logic start;
   logic done;
   logic is_fuse;
   logic is_load;

   assign wr_word = FLASH_WAW'({frame_r.hdr.hi, frame_r.hdr.lo});
   assign rd_word = FLASH_WAW'({hdr_r.hi, hdr_r.lo});
   assign is_load = frame_r.hdr.op == `ISP_OP_LD_LO ||
                    frame_r.hdr.op == `ISP_OP_LD_HI;
   assign is_fuse = frame_r.hdr.op == `ISP_OP_AC &&
                    (frame_r.hdr.hi == `ISP_WR_FUSE ||
                     frame_r.hdr.hi == `ISP_WR_FUSE_HI ||
                     frame_r.hdr.hi == `ISP_WR_FUSE_EXT ||
                     frame_r.hdr.hi == `ISP_WR_LOCK);

   always_comb begin
      kind = isp_pkg::ISP_OP_NONE;
      if (frame_r.hdr.op == `ISP_OP_WR_PAGE) begin
         kind = isp_pkg::ISP_OP_PAGE;
      end else if (frame_r.hdr.op == `ISP_OP_WR_EE) begin
         kind = isp_pkg::ISP_OP_EE;
      end else if (frame_r.hdr.op == `ISP_OP_AC &&
                   frame_r.hdr.hi == `ISP_OP_ERASE2) begin
         kind = isp_pkg::ISP_OP_ERASE;
      end else if (is_fuse) begin
         kind = isp_pkg::ISP_OP_FUSE;
      end
   end

   // new work is refused while one is pending
   assign start = wr_ev && enabled_r && op_r == isp_pkg::ISP_OP_NONE &&
                  kind != isp_pkg::ISP_OP_NONE;
   assign done = op_r != isp_pkg::ISP_OP_NONE && cnt_r == '0;

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         enabled_r <= 1'b0;
      end else if (!prog_act) begin
         enabled_r <= 1'b0;
      end else if (wr_ev && frame_r.hdr.op == `ISP_OP_AC &&
                   frame_r.hdr.hi == `ISP_OP_EN2) begin
         enabled_r <= 1'b1;
      end
   end

   // ==========================================
   // self-timed operations
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         op_r <= isp_pkg::ISP_OP_NONE;
         cnt_r <= '0;
         page_r <= '0;
         ee_addr_r <= '0;
         ee_data_r <= 8'h00;
      end else if (start) begin
         op_r <= kind;
         page_r <= wr_word[FLASH_WAW-1:PAGE_WAW];
         ee_addr_r <= EE_AW'({frame_r.hdr.hi, frame_r.hdr.lo});
         ee_data_r <= frame_r.data;
         case (kind)
            isp_pkg::ISP_OP_PAGE: cnt_r <= CNT_W'(PAGE_WAIT_CYC - 1);
            isp_pkg::ISP_OP_EE: cnt_r <= CNT_W'(EE_WAIT_CYC - 1);
            isp_pkg::ISP_OP_ERASE: cnt_r <= CNT_W'(ERASE_WAIT_CYC - 1);
            default: cnt_r <= CNT_W'(FUSE_WAIT_CYC - 1);
         endcase
      end else if (done) begin
         op_r <= isp_pkg::ISP_OP_NONE;
      end else if (op_r != isp_pkg::ISP_OP_NONE) begin
         cnt_r <= cnt_r - CNT_W'(1);
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pend_r <= 1'b0;
      end else begin
         pend_r <= start || (op_r != isp_pkg::ISP_OP_NONE && !done);
      end
   end

   assign OPERATION_PENDING_FLAG_O = pend_r;
   assign PROG_MODE_O = enabled_r;

   // ==========================================
   // fuses and lock bits; lock returns to ones by erase or by a lock write of ones
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         fuse_lo_r <= `ISP_FUSE_RST;
         fuse_hi_r <= `ISP_FUSE_RST;
         fuse_ext_r <= `ISP_FUSE_RST;
         lock_r <= `ISP_FUSE_RST;
      end else if (start && kind == isp_pkg::ISP_OP_ERASE) begin
         lock_r <= `ISP_ERASED;
      end else if (start && kind == isp_pkg::ISP_OP_FUSE) begin
         case (frame_r.hdr.hi)
            `ISP_WR_FUSE: fuse_lo_r <= frame_r.data;
            `ISP_WR_FUSE_HI: fuse_hi_r <= frame_r.data;
            `ISP_WR_FUSE_EXT: fuse_ext_r <= frame_r.data;
            default: lock_r <= frame_r.data;
         endcase
      end
   end

   // ==========================================
   // memory arrays; no reset, contents are non-volatile
   always_ff @(posedge CLK_SYS_I) begin
      if (wr_ev && enabled_r && is_load) begin
         pbuf[{wr_word[PAGE_WAW-1:0], frame_r.hdr.op[3]}] <=
            frame_r.data;
      end
      if (start && kind == isp_pkg::ISP_OP_ERASE) begin
         for (int i = 0; i < FLASH_BYTES; i++) begin
            flash_mem[i] <= `ISP_ERASED;
         end
         for (int i = 0; i < EE_BYTES; i++) begin
            ee_mem[i] <= `ISP_ERASED;
         end
      end
      if (start && kind == isp_pkg::ISP_OP_EE) begin
         ee_mem[EE_AW'({frame_r.hdr.hi, frame_r.hdr.lo})] <=
            `ISP_ERASED;
      end
      if (done && op_r == isp_pkg::ISP_OP_EE) begin
         ee_mem[ee_addr_r] <= ee_data_r;
      end
      if (done && op_r == isp_pkg::ISP_OP_PAGE) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            flash_mem[{page_r, PB_W'(i)}] <= pbuf[i];
         end
      end
   end

   // ==========================================
   // read answers, ready before the fourth byte goes out
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rd_byte_r <= `ISP_RD_NONE;
      end else if (rd_ev) begin
         if (!enabled_r) begin
            rd_byte_r <= `ISP_RD_NONE;
         end else begin
            case (hdr_r.op)
               `ISP_OP_RD_LO, `ISP_OP_RD_HI: begin
                  if (op_r == isp_pkg::ISP_OP_PAGE &&
                      rd_word[FLASH_WAW-1:PAGE_WAW] == page_r) begin
                     rd_byte_r <= `ISP_ERASED;
                  end else begin
                     rd_byte_r <= flash_mem[{rd_word, hdr_r.op[3]}];
                  end
               end
               `ISP_OP_RD_EE:
                  rd_byte_r <= ee_mem[EE_AW'({hdr_r.hi, hdr_r.lo})];
               `ISP_OP_POLL:
                  rd_byte_r <= {7'h00, op_r != isp_pkg::ISP_OP_NONE};
               `ISP_OP_RD_FUSE: rd_byte_r <= hdr_r.hi == `ISP_SEL_HI ?
                                             fuse_ext_r : fuse_lo_r;
               `ISP_OP_RD_LOCK: rd_byte_r <= hdr_r.hi == `ISP_SEL_HI ?
                                             fuse_hi_r : lock_r;
               `ISP_OP_RD_SIG: rd_byte_r <= SIGNATURE[8*hdr_r.lo[1:0]+:8];
               `ISP_OP_RD_CAL: rd_byte_r <= CALIBRATION;
               default: rd_byte_r <= `ISP_RD_NONE;
            endcase
         end
      end
   end

   // ==========================================
   // assertions
   a_echo_byte: assert property (
      @(posedge SER_CLK_I) disable iff (!sck_arst_n)
      bit_cnt_r == 5'h10 |-> out_sr_r == shift_in_r[7:0])
      else $error("second byte not echoed during third byte");

   a_out_falling: assert property (
      @(posedge SER_CLK_I) disable iff (!sck_arst_n)
      (bit_cnt_r > 5'h11 && bit_cnt_r < 5'h18) |->
      out_sr_r[7] == $past(out_sr_r[6]))
      else $error("serial output did not advance one bit");

   a_answer_load: assert property (
      @(posedge SER_CLK_I) disable iff (!sck_arst_n)
      bit_cnt_r == 5'h18 |-> out_sr_r == rd_byte_r)
      else $error("answer byte not presented in fourth byte");

   a_erase_ones: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      start && kind == isp_pkg::ISP_OP_ERASE |=>
      ee_mem[0] == 8'hff && flash_mem[0] == 8'hff && lock_r == 8'hff)
      else $error("chip erase left a location not all ones");

   a_ee_autoerase: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      start && kind == isp_pkg::ISP_OP_EE |=>
      ee_mem[ee_addr_r] == 8'hff && op_r == isp_pkg::ISP_OP_EE)
      else $error("data byte not erased at write start");

   a_ee_store: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      done && op_r == isp_pkg::ISP_OP_EE |=>
      ee_mem[$past(ee_addr_r)] == $past(ee_data_r))
      else $error("data byte not stored at write end");

   a_page_busy: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      rd_ev && enabled_r && op_r == isp_pkg::ISP_OP_PAGE &&
      hdr_r.op == 8'h20 && rd_word[FLASH_WAW-1:PAGE_WAW] == page_r
      |=> rd_byte_r == 8'hff)
      else $error("read inside page under write not all ones");

   a_page_commit: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      done && op_r == isp_pkg::ISP_OP_PAGE |=>
      flash_mem[{$past(page_r), PB_W'(1)}] == $past(pbuf[1]))
      else $error("page buffer not committed to selected page");

   a_no_enable: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      wr_ev && !enabled_r |=> op_r == isp_pkg::ISP_OP_NONE ||
      $past(op_r) != isp_pkg::ISP_OP_NONE)
      else $error("operation started before enable");

   a_poll_bit: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      rd_ev && enabled_r && hdr_r.op == 8'hf0 |=>
      rd_byte_r == {7'h00, $past(op_r) != isp_pkg::ISP_OP_NONE})
      else $error("poll answer does not show pending state");

   a_release_exit: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      !prog_act |=> !enabled_r ##1 !PROG_MODE_O || prog_act)
      else $error("programming mode held after reset release");

   c_enable: cover property (@(posedge CLK_SYS_I) $rose(enabled_r));
   c_page_done: cover property (@(posedge CLK_SYS_I)
      done && op_r == isp_pkg::ISP_OP_PAGE);
   c_ee_done: cover property (@(posedge CLK_SYS_I)
      done && op_r == isp_pkg::ISP_OP_EE);
   c_erase: cover property (@(posedge CLK_SYS_I)
      start && kind == isp_pkg::ISP_OP_ERASE);
endmodule // isp_port

// ==== dv/isp_prog_model.sv ====
// model of the external programmer on the serial link
`timescale 1ns/1ps
module isp_prog_model #(
   parameter int HALF_TICKS = 5,
   // shortened start-up wait, keeps the run short
   parameter int START_WAIT_NS = 2000
) (
   input wire logic lclk_i,
   input wire logic ser_data_i,
   output logic ser_clk_o,
   output logic ser_data_o,
   output logic prog_resetn_o
);
   // ==========================================
   // power-up levels
   initial begin
      ser_clk_o = 1'b0;
      ser_data_o = 1'b1;
      prog_resetn_o = 1'b0;
   end

   task automatic ticks(input int n);
      repeat (n) @(posedge lclk_i);
   endtask

   task automatic power_up();
      #(START_WAIT_NS);
   endtask

   // ==========================================
   // one frame, clock stands low outside it
   // low phases of five and high phases of six link ticks exceed the answer setup too
   task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
      for (int i = 31; i >= 0; i--) begin
         @(posedge lclk_i);
         ser_clk_o <= 1'b0;
         ser_data_o <= tx[i];
         ticks(HALF_TICKS - 1);
         @(posedge lclk_i);
         rx[i] = ser_data_i;
         ser_clk_o <= 1'b1;
         ticks(HALF_TICKS);
      end
      @(posedge lclk_i);
      ser_clk_o <= 1'b0;
      ser_data_o <= ~tx[0];
   endtask

   // reset pin level, held at least several cpu cycles
   task automatic set_pin(input logic level);
      @(posedge lclk_i);
      prog_resetn_o <= level;
      ticks(HALF_TICKS);
   endtask
endmodule // isp_prog_model

// ==== dv/serial_isp_programming_port_tb.sv ====
// self-checking bench of the serial programming port
`timescale 1ns/1ps
`include "isp_defs.svh"
module serial_isp_programming_port_tb;
   localparam int WAIT_CYC = 800;
   localparam int LIMIT = 60000;
   logic CLK_SYS_I = 1'b0;
   logic RESETN_I = 1'b0;
   logic lclk = 1'b0;
   logic PROG_RESETN_I;
   logic SER_CLK_I;
   logic SER_DATA_I;
   logic SER_DATA_O;
   logic PROG_MODE_O;
   logic OPERATION_PENDING_FLAG_O;
   logic [31:0] rx;
   int errors = 0;
   int checked = 0;
   int cycles = 0;

   // ==========================================
   // clocks and instances
   always #2 CLK_SYS_I = ~CLK_SYS_I;
   initial begin
      #1.3;
      forever #3 lclk = ~lclk;
   end

   // small geometry and waits keep polling loops short
   isp_port #(
      .FLASH_WAW(7), .PAGE_WAW(3), .EE_AW(4),
      .PAGE_WAIT_CYC(WAIT_CYC), .FUSE_WAIT_CYC(WAIT_CYC),
      .EE_WAIT_CYC(WAIT_CYC), .ERASE_WAIT_CYC(WAIT_CYC)
   ) DUT (
      .CLK_SYS_I(CLK_SYS_I),
      .RESETN_I(RESETN_I),
      .PROG_RESETN_I(PROG_RESETN_I),
      .SER_CLK_I(SER_CLK_I),
      .SER_DATA_I(SER_DATA_I),
      .SER_DATA_O(SER_DATA_O),
      .PROG_MODE_O(PROG_MODE_O),
      .OPERATION_PENDING_FLAG_O(OPERATION_PENDING_FLAG_O)
   );

   isp_prog_model PROG (
      .lclk_i(lclk),
      .ser_data_i(SER_DATA_O),
      .ser_clk_o(SER_CLK_I),
      .ser_data_o(SER_DATA_I),
      .prog_resetn_o(PROG_RESETN_I)
   );

   // ==========================================
   // helpers
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      if (errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic flags(input logic [7:0] mode, input logic [7:0] pend);
      repeat (6) @(posedge CLK_SYS_I);
      chk("mode", mode, {7'h0, PROG_MODE_O});
      chk("pending", pend, {7'h0, OPERATION_PENDING_FLAG_O});
   endtask

   task automatic poll_idle();
      int n;
      n = 0;
      do begin
         PROG.frame(32'hf0000000, rx);
         n++;
      end while (rx[0] !== 1'b0 && n < 8);
      chk("poll idle", 8'h00, {7'h0, rx[0]});
   endtask

   task automatic rd(input logic [7:0] op, input logic [7:0] a,
                     input logic [7:0] exp, input string what);
      PROG.frame({op, 8'h00, a, 8'h00}, rx);
      chk(what, exp, rx[7:0]);
   endtask

   task automatic ld(input logic [7:0] op, input logic [7:0] a,
                     input logic [7:0] d);
      PROG.frame({op, 8'h00, a, d}, rx);
   endtask

   // output only moves while the serial clock is low
   always @(SER_DATA_O) begin
      if (RESETN_I === 1'b1) begin
         chk("data out edge", 8'h00, {7'h0, SER_CLK_I});
      end
   end

   // ==========================================
   // scenarios
   task automatic t_refused();
      PROG.frame({`ISP_OP_WR_EE, 16'h0003, 8'h12}, rx);
      flags(8'h00, 8'h00);
   endtask

   task automatic t_enable();
      PROG.frame({`ISP_OP_AC, `ISP_OP_EN2, 16'h0000}, rx);
      chk("echo", `ISP_OP_EN2, rx[15:8]);
      flags(8'h01, 8'h00);
   endtask

   task automatic t_erase();
      PROG.frame({`ISP_OP_AC, `ISP_OP_ERASE2, 16'h0000}, rx);
      flags(8'h01, 8'h01);
      PROG.frame(32'hf0000000, rx);
      chk("poll busy", 8'h01, {7'h0, rx[0]});
      poll_idle();
      for (int a = 0; a < 16; a += 5) begin
         rd(`ISP_OP_RD_EE, 8'(a), `ISP_ERASED, "ee erased");
         rd(`ISP_OP_RD_HI, 8'(a * 7), `ISP_ERASED, "fl erased");
      end
   endtask

   task automatic t_ee();
      PROG.frame({`ISP_OP_WR_EE, 16'h0003, 8'h5a}, rx);
      rd(`ISP_OP_RD_EE, 8'h03, `ISP_ERASED, "ee busy");
      poll_idle();
      rd(`ISP_OP_RD_EE, 8'h03, 8'h5a, "ee data");
      // a plain and of old and new data would read zero here
      PROG.frame({`ISP_OP_WR_EE, 16'h0003, 8'ha5}, rx);
      poll_idle();
      rd(`ISP_OP_RD_EE, 8'h03, 8'ha5, "ee rewrite");
      PROG.frame({`ISP_OP_WR_EE, 16'h0003, 8'hff}, rx);
      repeat (WAIT_CYC + 16) @(posedge CLK_SYS_I);
      flags(8'h01, 8'h00);
      rd(`ISP_OP_RD_EE, 8'h03, 8'hff, "ee ones");
      rd(`ISP_OP_RD_EE, 8'h02, `ISP_ERASED, "ee other");
   endtask

   task automatic t_page();
      // high address bits on loads must not matter
      for (int w = 8; w < 10; w++) begin
         ld(`ISP_OP_LD_LO, 8'(w + 64), 8'(w + 16));
         ld(`ISP_OP_LD_HI, 8'(w + 64), 8'(w + 128));
      end
      PROG.frame({`ISP_OP_WR_PAGE, 16'h0008, 8'h00}, rx);
      rd(`ISP_OP_RD_LO, 8'h09, `ISP_ERASED, "page busy");
      poll_idle();
      for (int w = 8; w < 10; w++) begin
         rd(`ISP_OP_RD_LO, 8'(w), 8'(w + 16), "flash lo");
         rd(`ISP_OP_RD_HI, 8'(w), 8'(w + 128), "flash hi");
      end
      rd(`ISP_OP_RD_LO, 8'h48, `ISP_ERASED, "other page");
      // all-ones data cannot be polled, so the full delay is waited
      ld(`ISP_OP_LD_LO, 8'h08, 8'hff);
      PROG.frame({`ISP_OP_WR_PAGE, 16'h0008, 8'h00}, rx);
      repeat (WAIT_CYC + 16) @(posedge CLK_SYS_I);
      flags(8'h01, 8'h00);
      rd(`ISP_OP_RD_LO, 8'h08, 8'hff, "flash ones");
      rd(`ISP_OP_RD_HI, 8'h09, 8'h89, "flash kept");
   endtask

   task automatic t_fuse();
      PROG.frame({`ISP_OP_AC, `ISP_WR_FUSE, 16'h003c}, rx);
      flags(8'h01, 8'h01);
      repeat (WAIT_CYC + 16) @(posedge CLK_SYS_I);
      flags(8'h01, 8'h00);
      rd(`ISP_OP_RD_FUSE, 8'h00, 8'h3c, "fuse low");
      rd(`ISP_OP_RD_LOCK, 8'h00, `ISP_ERASED, "lock");
   endtask

   task automatic t_session();
      PROG.set_pin(1'b1);
      repeat (6) @(posedge CLK_SYS_I);
      chk("mode off", 8'h00, {7'h0, PROG_MODE_O});
      PROG.set_pin(1'b0);
      PROG.frame({`ISP_OP_WR_EE, 16'h0003, 8'h00}, rx);
      flags(8'h00, 8'h00);
      t_enable();
      rd(`ISP_OP_RD_EE, 8'h03, 8'hff, "ee kept");
   endtask

   // ==========================================
   // sequence and hang guard
   always @(posedge CLK_SYS_I) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         summarize();
      end
   end

   initial begin
      repeat (5) @(posedge CLK_SYS_I);
      RESETN_I <= 1'b1;
      PROG.power_up();
      t_refused();
      t_enable();
      t_erase();
      t_fuse();
      t_ee();
      t_page();
      t_session();
      summarize();
   end
endmodule // serial_isp_programming_port_tb
